// *** modem_consts.vh ***
`ifndef MODEM_CONSTS_VH
`define MODEM_CONSTS_VH

// operating modes
`define MODE_NORMAL      2'h0
`define MODE_WAKE        2'h1
`define MODE_CONFIG      2'h2
`define MODE_SLEEP       2'h3

// register indices on the software port
`define REG_CTRL         4'h0
`define REG_ADDR         4'h1
`define REG_STATUS       4'h2
`define REG_TX_LEVEL     4'h3
`define REG_PREAMBLE     4'h4

// control field positions
`define CTRL_PKT_LO      0
`define CTRL_PKT_HI      1
`define CTRL_CFG_EN      2

// packet size encodings
`define PKT_32           2'h0
`define PKT_64           2'h1
`define PKT_128          2'h2
`define PKT_240          2'h3
`define PKT_LEN_32       8'h20
`define PKT_LEN_64       8'h40
`define PKT_LEN_128      8'h80
`define PKT_LEN_240      8'hf0

// resets and special values
`define CTRL_RESET       3'h0
`define ADDR_RESET       16'h0000
`define ADDR_ALL_ONES    16'hffff
`define PREAMBLE_RESET   8'h08
`define WAKE_BYTE        8'h55
`define OTA_CFG_BYTE     8'hcf

// timing
`define CLK_HZ           20000000
`define CFG_BAUD         9600
`define BAUD_DIV         (`CLK_HZ / `CFG_BAUD)
`define STABLE_CYCLES    16'h0100
`define REAPPLY_CYCLES   16'h0400

`endif

// *** mode_filter.v ***
`timescale 1ns/100ps
`include "modem_consts.vh"

module mode_filter #(
    parameter STABLE = `STABLE_CYCLES
) (
    // clock and reset
    input  wire       core_clk,
    input  wire       rst_n,
    // switches
    input  wire       mode_select_high,
    input  wire       mode_select_low,
    // decoded
    output reg  [1:0] mode_reg
);
    reg  [1:0]  sync1_reg;
    reg  [1:0]  sync2_reg;
    reg  [1:0]  last_reg;
    reg  [15:0] cnt_reg;
    wire [1:0]  dec;

    // both on = 0, high only = 1, low only = 2, none = 3
    assign dec = {~sync2_reg[1], ~sync2_reg[0]};

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 2'h3;
            sync2_reg <= 2'h3;
            last_reg  <= `MODE_NORMAL;
            cnt_reg   <= 16'h0000;
            mode_reg  <= `MODE_NORMAL;
        end else begin
            sync1_reg <= {mode_select_high, mode_select_low};
            sync2_reg <= sync1_reg;
            last_reg  <= dec;
            if (dec != last_reg) begin
                cnt_reg <= 16'h0000;
            end else if (cnt_reg != STABLE) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end else begin
                mode_reg <= dec;
            end
        end
    end
endmodule

// *** radio_modem.v ***
// Operation
// - two switches decode to normal, wake, configuration and sleep modes.
// - after reset the device runs in normal mode.
// - normal mode transmits host serial bytes over the radio.
// - normal mode keeps receiver on and forwards payloads to host.
// - normal mode accepts register writes when CTRL_CFG_EN is set, transfer stays on.
// - wake mode prepends a wake preamble to each transmission.
// - wake mode receives exactly as normal mode.
// - configuration mode disables radio transmit and receive.
// - configuration mode gives host register access over serial.
// - sleep mode neither transmits nor relays serial data.
// - packets split at 32, 64, 128 or 240 bytes by command.
// - at most 1000 bytes buffered; excess host data refused.
// - remainder beyond one packet goes out in further packets.
// - own address all ones makes transmissions broadcast.
// - own address all ones accepts every target address.
// - leaving sleep, busy low while reapplying, then high.
// - configuration serial runs fixed 9600 baud 8N1.
`timescale 1ns/100ps
`include "modem_consts.vh"

module radio_modem #(
    parameter DEPTH   = 1000,
    parameter REAPPLY = `REAPPLY_CYCLES
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // mode switches
    input  wire        mode_select_high,
    input  wire        mode_select_low,
    // host byte stream from serial receiver
    input  wire        host_rx_valid,
    input  wire [7:0]  host_rx_data,
    output wire        host_rx_ready,
    // bytes to host serial transmitter
    output reg         host_tx_valid,
    output reg  [7:0]  host_tx_data,
    // radio transmit side
    output reg         radio_tx_valid,
    output reg  [7:0]  radio_tx_data,
    output reg         radio_tx_first,
    output reg         radio_tx_last,
    output reg  [15:0] radio_tx_dest,
    input  wire        radio_tx_ready,
    // radio receive side
    input  wire        radio_rx_valid,
    input  wire [7:0]  radio_rx_data,
    input  wire [15:0] radio_rx_dest,
    input  wire [15:0] radio_rx_src,
    output wire        radio_rx_enable,
    output wire        radio_tx_enable,
    // software register port
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    // status
    output wire [1:0]  mode,
    output reg         busy_n,
    output wire        cfg_baud_tick
);
    localparam S_IDLE = 4'h1;
    localparam S_PRE  = 4'h2;
    localparam S_DATA = 4'h4;
    localparam S_GAP  = 4'h8;

    reg  [2:0]  ctrl_reg;
    reg  [15:0] own_addr_reg;
    reg  [7:0]  preamble_reg;
    reg  [7:0]  mem [0:DEPTH-1];
    reg  [9:0]  wr_ptr_reg;
    reg  [9:0]  rd_ptr_reg;
    reg  [10:0] level_reg;
    reg  [3:0]  state_reg;
    reg  [7:0]  pkt_cnt_reg;
    reg  [7:0]  pre_cnt_reg;
    reg  [1:0]  prev_mode_reg;
    reg  [15:0] reapply_reg;
    reg  [15:0] baud_cnt_reg;
    reg  [7:0]  rx_prev_reg;
    wire [1:0]  cur_mode;
    wire        push;
    wire        pop;
    wire        radio_on;
    wire        addr_ok;
    wire [7:0]  pkt_max;

    function [9:0] ptr_inc;
        input [9:0] p;
        begin
            if (p == DEPTH - 1)
                ptr_inc = 10'h000;
            else
                ptr_inc = p + 10'h001;
        end
    endfunction

    function [7:0] pkt_len;
        input [1:0] sel;
        begin
            case (sel)
                `PKT_32:  pkt_len = `PKT_LEN_32;
                `PKT_64:  pkt_len = `PKT_LEN_64;
                `PKT_128: pkt_len = `PKT_LEN_128;
                default:  pkt_len = `PKT_LEN_240;
            endcase
        end
    endfunction

    mode_filter u_mode (
        .core_clk         (core_clk),
        .rst_n            (rst_n),
        .mode_select_high (mode_select_high),
        .mode_select_low  (mode_select_low),
        .mode_reg         (cur_mode)
    );
    assign mode = cur_mode;

    ////////////////////////////////////////////////////////////////////////
    // radio gating

    // config and sleep keep radio off
    assign radio_on = busy_n &&
                      (cur_mode == `MODE_NORMAL || cur_mode == `MODE_WAKE);
    assign radio_rx_enable = radio_on;
    assign radio_tx_enable = radio_on;
    assign pkt_max = pkt_len(ctrl_reg[`CTRL_PKT_HI:`CTRL_PKT_LO]);

    ////////////////////////////////////////////////////////////////////////
    // transmit buffer

    // refuse bytes once 1000 are held
    assign host_rx_ready = radio_on && (level_reg != DEPTH);
    assign push = host_rx_valid && host_rx_ready;
    assign pop  = (state_reg == S_DATA) && radio_tx_ready && radio_on;

    always @(posedge core_clk) begin
        if (push)
            mem[wr_ptr_reg] <= host_rx_data;
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= 10'h000;
            rd_ptr_reg <= 10'h000;
            level_reg  <= 11'h000;
        end else begin
            if (push)
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            if (pop)
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            if (push && !pop)
                level_reg <= level_reg + 11'h001;
            else if (pop && !push)
                level_reg <= level_reg - 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // packetizer

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= S_IDLE;
            pkt_cnt_reg    <= 8'h00;
            pre_cnt_reg    <= 8'h00;
            radio_tx_valid <= 1'b0;
            radio_tx_data  <= 8'h00;
            radio_tx_first <= 1'b0;
            radio_tx_last  <= 1'b0;
            radio_tx_dest  <= `ADDR_RESET;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    radio_tx_valid <= 1'b0;
                    radio_tx_last  <= 1'b0;
                    if (radio_on && level_reg != 11'h000) begin
                        pkt_cnt_reg    <= 8'h00;
                        pre_cnt_reg    <= 8'h00;
                        radio_tx_first <= 1'b1;
                        radio_tx_dest  <= own_addr_reg;
                        if (cur_mode == `MODE_WAKE)
                            state_reg <= S_PRE;
                        else
                            state_reg <= S_DATA;
                    end
                end
                S_PRE: begin
                    radio_tx_valid <= 1'b1;
                    radio_tx_data  <= `WAKE_BYTE;
                    if (radio_tx_ready && radio_tx_valid) begin
                        radio_tx_first <= 1'b0;
                        pre_cnt_reg    <= pre_cnt_reg + 8'h01;
                        // last preamble byte taken, no stale repeat
                        if (pre_cnt_reg + 8'h01 >= preamble_reg) begin
                            radio_tx_valid <= 1'b0;
                            state_reg      <= S_DATA;
                        end
                    end
                end
                S_DATA: begin
                    if (!radio_on) begin
                        radio_tx_valid <= 1'b0;
                        state_reg      <= S_IDLE;
                    end else if (radio_tx_ready) begin
                        radio_tx_valid <= 1'b1;
                        radio_tx_data  <= mem[rd_ptr_reg];
                        pkt_cnt_reg    <= pkt_cnt_reg + 8'h01;
                        if (pkt_cnt_reg != 8'h00)
                            radio_tx_first <= 1'b0;
                        if (pkt_cnt_reg + 8'h01 == pkt_max ||
                            level_reg == 11'h001) begin
                            radio_tx_last <= 1'b1;
                            state_reg     <= S_GAP;
                        end
                    end
                end
                S_GAP: begin
                    if (radio_tx_ready) begin
                        radio_tx_valid <= 1'b0;
                        radio_tx_last  <= 1'b0;
                        radio_tx_first <= 1'b0;
                        state_reg      <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive path

    assign addr_ok = (own_addr_reg == `ADDR_ALL_ONES) ||
                     (radio_rx_dest == `ADDR_ALL_ONES) ||
                     (radio_rx_dest == own_addr_reg);

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_tx_valid <= 1'b0;
            host_tx_data  <= 8'h00;
            rx_prev_reg   <= 8'h00;
        end else begin
            host_tx_valid <= radio_on && radio_rx_valid && addr_ok;
            host_tx_data  <= radio_rx_data;
            if (radio_on && radio_rx_valid)
                rx_prev_reg <= radio_rx_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers, busy and config baud

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_mode_reg <= `MODE_NORMAL;
            reapply_reg   <= 16'h0000;
            busy_n        <= 1'b1;
        end else begin
            prev_mode_reg <= cur_mode;
            if (prev_mode_reg == `MODE_SLEEP && cur_mode != `MODE_SLEEP) begin
                reapply_reg <= REAPPLY[15:0];
                busy_n      <= 1'b0;
            end else if (reapply_reg != 16'h0000) begin
                reapply_reg <= reapply_reg - 16'h0001;
                busy_n      <= (reapply_reg == 16'h0001);
            end
        end
    end

    // fixed 9600 baud tick in config
    assign cfg_baud_tick = (cur_mode == `MODE_CONFIG) &&
                           (baud_cnt_reg == `BAUD_DIV - 1);
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            baud_cnt_reg <= 16'h0000;
        else if (cur_mode != `MODE_CONFIG || cfg_baud_tick)
            baud_cnt_reg <= 16'h0000;
        else
            baud_cnt_reg <= baud_cnt_reg + 16'h0001;
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg     <= `CTRL_RESET;
            own_addr_reg <= `ADDR_RESET;
            preamble_reg <= `PREAMBLE_RESET;
        end else if (reg_wr && (cur_mode == `MODE_CONFIG ||
                     (cur_mode == `MODE_NORMAL && ctrl_reg[`CTRL_CFG_EN]))) begin
            case (reg_addr)
                `REG_CTRL:     ctrl_reg     <= reg_wdata[2:0];
                `REG_ADDR:     own_addr_reg <= reg_wdata;
                `REG_PREAMBLE: preamble_reg <= reg_wdata[7:0];
                default:       ctrl_reg     <= ctrl_reg;
            endcase
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL:     reg_rdata <= {13'h0000, ctrl_reg};
                `REG_ADDR:     reg_rdata <= own_addr_reg;
                `REG_STATUS:   reg_rdata <= {8'h00, rx_prev_reg[3:0],
                                             state_reg[1:0] == 2'h0,
                                             busy_n, cur_mode};
                `REG_TX_LEVEL: reg_rdata <= {5'h00, level_reg};
                `REG_PREAMBLE: reg_rdata <= {8'h00, preamble_reg};
                default:       reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

// *** radio_modem_chk.sv ***
`timescale 1ns/100ps
module radio_modem_chk (
    // clock and reset
    input wire        core_clk,
    input wire        rst_n,
    // watched ports
    input wire        mode_select_high,
    input wire        mode_select_low,
    input wire        host_rx_ready,
    input wire        host_tx_valid,
    input wire [7:0]  host_tx_data,
    input wire        radio_rx_valid,
    input wire [7:0]  radio_rx_data,
    input wire [15:0] radio_rx_dest,
    input wire        radio_rx_enable,
    input wire        radio_tx_enable,
    input wire [1:0]  mode,
    input wire        busy_n,
    input wire        cfg_baud_tick
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    cfg_off_a: assert property (
        mode == 2'h2 |-> !radio_tx_enable && !radio_rx_enable)
        else $error("radio enabled in config mode");
    sleep_off_a: assert property (
        mode == 2'h3 |-> !radio_tx_enable && !host_rx_ready)
        else $error("traffic allowed in sleep");
    rx_on_a: assert property (
        !mode[1] && busy_n |-> radio_rx_enable && radio_tx_enable)
        else $error("radio off in normal or wake");
    fwd_src_a: assert property (
        host_tx_valid |-> $past(radio_rx_valid && radio_rx_enable)
        && host_tx_data == $past(radio_rx_data))
        else $error("host byte without radio byte");
    bcast_rx_a: assert property (
        radio_rx_valid && radio_rx_enable && radio_rx_dest == 16'hffff
        |=> host_tx_valid)
        else $error("broadcast byte dropped");
    busy_rise_a: assert property (
        $fell(busy_n) |-> !busy_n [*8] ##[1:40] busy_n)
        else $error("busy low too short or too long");
    mode_dec_a: assert property (
        $changed(mode) |-> mode == {~$past(mode_select_high, 4),
        ~$past(mode_select_low, 4)})
        else $error("mode differs from settled switches");
    tick_cfg_a: assert property (
        cfg_baud_tick |-> mode == 2'h2 ##1 !cfg_baud_tick [*8])
        else $error("baud tick outside config or too close");
endmodule

// *** host_term.sv ***
`timescale 1ns/100ps
module host_term (
    // clock
    input  wire       core_clk,
    // byte stream into the modem
    output reg        host_rx_valid,
    output reg  [7:0] host_rx_data,
    input  wire       host_rx_ready
);
    initial begin
        host_rx_valid = 1'b0;
        host_rx_data = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // offer held until taken
    task send(input [7:0] v, output bit ok);
        int k;
        host_rx_valid <= 1'b1;
        host_rx_data <= v;
        ok = 1'b0;
        for (k = 0; k < 4000 && !ok; k++) begin
            @(negedge core_clk);
            ok = (host_rx_ready === 1'b1);
            @(posedge core_clk);
        end
    endtask
    // released line shows inverted data
    task idle;
        host_rx_valid <= 1'b0;
        host_rx_data <= ~host_rx_data;
    endtask
endmodule

// *** tb_radio_modem.sv ***
`timescale 1ns/100ps
`include "modem_consts.vh"
module tb_radio_modem;
    reg        core_clk = 1'b0, rst_n = 1'b0, radio_tx_ready = 1'b0;
    reg        mode_select_high = 1'b1, mode_select_low = 1'b1;
    reg        radio_rx_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg [7:0]  radio_rx_data = 8'h00, b;
    reg [15:0] radio_rx_dest = 16'h0000, radio_rx_src = 16'h0000;
    reg [15:0] reg_wdata = 16'h0000, own;
    reg [3:0]  reg_addr = 4'h0;
    wire       host_rx_valid, host_rx_ready, host_tx_valid, busy_n;
    wire       radio_tx_valid, radio_tx_first, radio_tx_last;
    wire       radio_rx_enable, radio_tx_enable, cfg_baud_tick;
    wire [7:0] host_rx_data, host_tx_data, radio_tx_data;
    wire [15:0] radio_tx_dest, reg_rdata;
    wire [1:0] mode;
    logic [15:0] rq[$];
    logic [7:0]  hq[$];
    logic [25:0] tq[$];
    int        err_total, cmp_count, i, n, sz, len;
    bit        ok, rd_d;

    radio_modem #(.DEPTH(1000), .REAPPLY(16)) dut_u (
        .core_clk, .rst_n, .mode_select_high, .mode_select_low,
        .host_rx_valid, .host_rx_data, .host_rx_ready,
        .host_tx_valid, .host_tx_data, .radio_tx_valid, .radio_tx_data,
        .radio_tx_first, .radio_tx_last, .radio_tx_dest, .radio_tx_ready,
        .radio_rx_valid, .radio_rx_data, .radio_rx_dest, .radio_rx_src,
        .radio_rx_enable, .radio_tx_enable, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .mode, .busy_n, .cfg_baud_tick
    );
    host_term host_u (.core_clk, .host_rx_valid, .host_rx_data,
        .host_rx_ready);
    ////////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string what, input logic [25:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // 0..3 mode settled, 4 all results seen, 5 busy low
    task wt(input int m);
        int k;
        for (k = 0; k < 3000; k++) begin
            @(posedge core_clk);
            if (m == 5 ? busy_n === 1'b0 : m == 4 ?
                tq.size() + hq.size() + rq.size() == 0 :
                mode === m[1:0] && busy_n === 1'b1)
                break;
        end
        if (k == 3000) begin
            err_total++;
            wrap_up;
        end
    endtask
    task sw(input [1:0] m);
        mode_select_high <= ~m[1];
        mode_select_low <= ~m[0];
        wt(m);
    endtask
    task acc(input bit w, input [3:0] a, input [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        if (!w)
            rq.push_back(d);
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task rx(input [15:0] d, input bit fwd);
        @(posedge core_clk);
        b = 8'($urandom);
        radio_rx_valid <= 1'b1;
        radio_rx_data <= b;
        radio_rx_dest <= d;
        radio_rx_src <= 16'($urandom);
        if (fwd)
            hq.push_back(b);
        @(posedge core_clk);
        radio_rx_valid <= 1'b0;
        radio_rx_data <= ~b;
        radio_rx_dest <= ~d;
    endtask
    task push(input [7:0] v, input bit f, l, s);
        tq.push_back({own, f, l, v});
        if (s)
            host_u.send(v, ok);
        if (s && !ok) begin
            err_total++;
            wrap_up;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(negedge core_clk) begin
        if (rd_d)
            chk("reg_rdata", reg_rdata,
                rq.size() ? rq.pop_front() : 'x);
        rd_d = reg_rd;
        if (host_tx_valid !== 1'b0)
            chk("host_tx", host_tx_data,
                hq.size() ? hq.pop_front() : 'x);
        if (radio_tx_valid !== 1'b0 && radio_tx_ready)
            chk("radio_tx", {radio_tx_dest, radio_tx_first,
                radio_tx_last, radio_tx_data},
                tq.size() ? tq.pop_front() : 'x);
    end
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        b = 8'($urandom(39916));
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk("mode", mode, `MODE_NORMAL);
        chk("busy_n", busy_n, 1'b1);
        acc(0, `REG_CTRL, 16'h0000);
        acc(0, `REG_ADDR, `ADDR_RESET);
        acc(0, `REG_PREAMBLE, 16'h0008);
        acc(0, 4'hf, 16'h0000);
        sw(`MODE_CONFIG);
        @(negedge core_clk);
        chk("host_rx_ready", host_rx_ready, 1'b0);
        rx(16'hffff, 0);
        acc(1, `REG_CTRL, 16'h0004);
        acc(1, `REG_ADDR, `ADDR_ALL_ONES);
        acc(1, 4'he, 16'h1234);
        acc(0, `REG_ADDR, `ADDR_ALL_ONES);
        own = `ADDR_ALL_ONES;
        n = 0;
        sz = 0;
        for (i = 0; i < 5000 && n < 2; i++) begin
            @(negedge core_clk);
            if (cfg_baud_tick === 1'b1)
                n++;
            else if (n == 1)
                sz++;
        end
        chk("baud_period", sz + 1, `BAUD_DIV);
        sw(`MODE_NORMAL);
        for (sz = 0; sz < 4; sz++) begin
            len = (sz == 3) ? 240 : 32 << sz;
            n = (sz == 3) ? 1000 : 2 * len + 5;
            acc(1, `REG_CTRL, {14'h0001, sz[1:0]});
            radio_tx_ready <= 1'b0;
            for (i = 0; i < n; i++)
                push(8'($urandom), i % len == 0,
                    i % len == len - 1 || i == n - 1, 1);
            host_u.idle;
            @(negedge core_clk);
            chk("host_rx_ready", host_rx_ready, sz != 3);
            acc(0, `REG_TX_LEVEL, n[15:0]);
            @(posedge core_clk);
            radio_tx_ready <= 1'b1;
            wt(4);
        end
        rx(16'h1234, 1);
        acc(1, `REG_ADDR, 16'h0012);
        own = 16'h0012;
        rx(16'h0034, 0);
        rx(16'hffff, 1);
        rx(16'h0012, 1);
        sw(`MODE_WAKE);
        radio_tx_ready <= 1'b0;
        for (i = 0; i < 8; i++)
            push(`WAKE_BYTE, i == 0, 0, 0);
        for (i = 0; i < 3; i++)
            push(8'($urandom), 0, i == 2, 1);
        host_u.idle;
        @(posedge core_clk);
        radio_tx_ready <= 1'b1;
        rx(16'h0012, 1);
        wt(4);
        sw(`MODE_SLEEP);
        @(negedge core_clk);
        chk("host_rx_ready", host_rx_ready, 1'b0);
        rx(16'hffff, 0);
        mode_select_high <= 1'b1;
        mode_select_low <= 1'b1;
        wt(5);
        chk("mode", mode, `MODE_NORMAL);
        wt(`MODE_NORMAL);
        wt(4);
        wrap_up;
    end
endmodule
////////////////////////////////////////////////////////////////////////////
bind radio_modem radio_modem_chk chk_u (
    .core_clk, .rst_n, .mode_select_high, .mode_select_low,
    .host_rx_ready, .host_tx_valid, .host_tx_data, .radio_rx_valid,
    .radio_rx_data, .radio_rx_dest, .radio_rx_enable, .radio_tx_enable,
    .mode, .busy_n, .cfg_baud_tick
);
